//--- fbdc_consts.svh
`ifndef FBDC_CONSTS_SVH
`define FBDC_CONSTS_SVH

// register offsets (byte addresses within a page)
`define FBDC_OFF_PAGE 7'h00
`define FBDC_OFF_PINFN 7'h06
`define FBDC_OFF_FLT_LO 7'h16
`define FBDC_OFF_FLT_HI 7'h18
`define FBDC_OFF_COEF_FIRST 7'h08
`define FBDC_OFF_COEF_LAST 7'h7e

// pages
`define FBDC_PAGE_CTRL 8'h03
`define FBDC_PAGE_BANK0 8'h05
`define FBDC_PAGE_BANK_LAST 8'h0c
`define FBDC_TAPS_PER_PAGE 60
`define FBDC_TAPS 120

// reset values
`define FBDC_RST_PINFN 16'h000d
`define FBDC_RST_FLT 16'h0000
`define FBDC_RST_PAGE 8'h00

// pin-function fields
`define FBDC_SYNC_EN 7
`define FBDC_SYNC_EDGE 6
`define FBDC_SYNC_PIN_HI 5
`define FBDC_SYNC_PIN_LO 4
`define FBDC_DR_EN 3
`define FBDC_DR_POL 2
`define FBDC_DR_PIN_HI 1
`define FBDC_DR_PIN_LO 0

// filter-select fields
`define FBDC_YA_EN 14
`define FBDC_YA_BK 13
`define FBDC_XA_EN 11
`define FBDC_XA_BK 10
`define FBDC_ZA_EN 2
`define FBDC_ZA_BK 1
`define FBDC_XM_EN 5
`define FBDC_XM_BK 4
`define FBDC_YM_EN 8
`define FBDC_YM_BK 7
`define FBDC_ZM_EN 11
`define FBDC_ZM_BK 10

// internal sample clock
`define FBDC_SAMPLE_HZ 3200
`define FBDC_CLK_HZ 100000000
`define FBDC_SAMPLE_DIV (`FBDC_CLK_HZ / `FBDC_SAMPLE_HZ)

`endif

//--- fbdc_pkg.sv
package fbdc_pkg;
  typedef struct packed {
    logic en;
    logic [1:0] bank;
  } fbdc_axis_type;

  typedef struct packed {
    fbdc_axis_type ya;
    fbdc_axis_type xa;
    fbdc_axis_type za;
    fbdc_axis_type xm;
    fbdc_axis_type ym;
    fbdc_axis_type zm;
  } fbdc_axes_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [15:0] wdata;
  } fbdc_req_type;
endpackage

//--- fbdc_gpio_route.sv
`timescale 1ns/10ps
`include "fbdc_consts.svh"
module fbdc_gpio_route (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration
  input wire logic sync_en,
  input wire logic sync_rise,
  input wire logic [1:0] sync_pin,
  input wire logic dr_en,
  input wire logic dr_high,
  input wire logic [1:0] dr_pin,
  input wire logic data_ready,
  input wire logic [3:0] gp_out,
  input wire logic [3:0] gp_oe_n,
  // pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  // results
  output logic [3:0] gp_in,
  output logic sync_edge
);
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic prev_ff;
  logic [3:0] cfg_ff;
  logic sel_lvl;

  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
    end
  end

  assign sel_lvl = sync_ff[sync_pin] ^ ~sync_rise;

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_ff <= 1'b0;
      cfg_ff <= 4'h0;
    end else begin
      prev_ff <= sel_lvl;
      cfg_ff <= {sync_en, sync_rise, sync_pin};
    end
  end

  // a new pin or polarity would fake an edge; count only once the setting has stood a cycle
  assign sync_edge = sync_en & sel_lvl & ~prev_ff & (cfg_ff == {sync_en, sync_rise, sync_pin});
  assign gp_in = sync_ff;

  always_comb begin
    pin_out = gp_out;
    pin_oe_n = gp_oe_n;
    if (sync_en) begin
      pin_oe_n[sync_pin] = 1'b1;
      pin_out[sync_pin] = 1'b0;
    end
    if (dr_en) begin
      pin_oe_n[dr_pin] = 1'b0;
      pin_out[dr_pin] = ~(data_ready ^ dr_high);
    end
  end
endmodule

//--- fbdc_top.sv
`timescale 1ns/10ps
`include "fbdc_consts.svh"
// Behaviour
// - lower reg bit14 enables Y accel, 13:12 bank
// - bit11 enables X accel, 10:9 bank
// - upper reg bit2 Z accel, 1:0 bank
// - bit5 X mag, 4:3 bank
// - bit8 Y mag, 7:6 bank
// - bit11 Z mag, 10:9 bank; 15:12 ignored
// - banks on page pairs 5-6 through 11-12
// - taps at even offsets 0x08..0x7e
// - banks preloaded with factory low-pass designs
// - bank delay is half its tap count
// - each pin carries one function only
// - conflict clears lower-priority enable automatically
// - bit7 sync enable, 6 edge, 5:4 pin
// - bit3 ready enable, 2 polarity, 1:0 pin
// - pin-function register resets to 0x000d
// - sync enable stops internal sample clock
// - filter-select registers reset to zero
// - filter settings apply on upper-byte write
module fbdc_top #(
  parameter int TAPS = `FBDC_TAPS,
  parameter int SAMPLE_DIV = `FBDC_SAMPLE_DIV
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port, byte-lane access
  input wire fbdc_pkg::fbdc_req_type req,
  input wire logic [1:0] byte_en,
  output logic [15:0] rdata_ff,
  // sample path
  input wire logic data_ready,
  output fbdc_pkg::fbdc_axes_type axes_active,
  output logic sample_tick,
  output logic sync_mode,
  output logic [7:0] axis_delay,
  // coefficient read port for the datapath
  input wire logic [1:0] coef_bank,
  input wire logic [6:0] coef_tap,
  output logic [15:0] coef_ff,
  // general-purpose pins
  input wire logic [3:0] gp_out,
  input wire logic [3:0] gp_oe_n,
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  output logic [3:0] gp_in
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] page_ff;
  logic [15:0] pinfn_ff;
  logic [15:0] flt_lo_ff;
  logic [15:0] flt_hi_ff;
  logic [15:0] flt_lo_live_ff;
  logic [15:0] flt_hi_live_ff;
  logic [15:0] coef_mem [0:4*TAPS-1];
  logic [15:0] nxt_pinfn;
  logic [15:0] nxt_rdata;
  logic [31:0] div_ff;
  logic sync_edge;
  logic ctrl_page;
  logic coef_hit;
  logic [8:0] coef_idx;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // page pair and offset to flat tap index
  function automatic logic [8:0] tap_index(input logic [7:0] pg, input logic [6:0] off);
    logic [7:0] rel;
    logic [8:0] tap;
    rel = pg - `FBDC_PAGE_BANK0;
    tap = 9'(off[6:1]) - 9'd4 + (rel[0] ? 9'(`FBDC_TAPS_PER_PAGE) : 9'd0);
    tap_index = 9'(rel[2:1]) * 9'(TAPS) + tap;
  endfunction

  function automatic logic [15:0] factory_tap(input int bank, input int t);
    int n;
    n = (bank < 2) ? 120 : 32;
    factory_tap = (t < n) ? 16'(32768 / n) : 16'h0000;
  endfunction

  assign ctrl_page = page_ff == `FBDC_PAGE_CTRL;
  assign coef_hit = page_ff >= `FBDC_PAGE_BANK0 && page_ff <= `FBDC_PAGE_BANK_LAST
                    && req.addr >= `FBDC_OFF_COEF_FIRST && !req.addr[0];
  assign coef_idx = tap_index(page_ff, req.addr);

  ////////////////////////////////////////////////////////////////////////////
  // page selector
  always_ff @(posedge clock) begin
    if (rst) begin
      page_ff <= `FBDC_RST_PAGE;
    end else if (req.wr && req.addr == `FBDC_OFF_PAGE && byte_en[0]) begin
      page_ff <= req.wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin function with conflict resolution
  always_comb begin
    nxt_pinfn = merge(pinfn_ff, req.wdata, byte_en);
    nxt_pinfn[15:8] = 8'h00;
    if (nxt_pinfn[`FBDC_DR_EN] && nxt_pinfn[`FBDC_SYNC_EN]
        && nxt_pinfn[`FBDC_SYNC_PIN_HI:`FBDC_SYNC_PIN_LO]
           == nxt_pinfn[`FBDC_DR_PIN_HI:`FBDC_DR_PIN_LO]) begin
      nxt_pinfn[`FBDC_SYNC_EN] = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pinfn_ff <= `FBDC_RST_PINFN;
    end else if (req.wr && ctrl_page && req.addr == `FBDC_OFF_PINFN) begin
      pinfn_ff <= nxt_pinfn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter select: staged, applied on upper-byte write
  always_ff @(posedge clock) begin
    if (rst) begin
      flt_lo_ff <= `FBDC_RST_FLT;
      flt_lo_live_ff <= `FBDC_RST_FLT;
    end else if (req.wr && ctrl_page && req.addr == `FBDC_OFF_FLT_LO) begin
      flt_lo_ff <= merge(flt_lo_ff, req.wdata, byte_en);
      if (byte_en[1]) begin
        flt_lo_live_ff <= merge(flt_lo_ff, req.wdata, byte_en);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flt_hi_ff <= `FBDC_RST_FLT;
      flt_hi_live_ff <= `FBDC_RST_FLT;
    end else if (req.wr && ctrl_page && req.addr == `FBDC_OFF_FLT_HI) begin
      flt_hi_ff <= merge(flt_hi_ff, req.wdata, byte_en) & 16'h0fff;
      if (byte_en[1]) begin
        flt_hi_live_ff <= merge(flt_hi_ff, req.wdata, byte_en) & 16'h0fff;
      end
    end
  end

  assign axes_active.ya = {flt_lo_live_ff[`FBDC_YA_EN], flt_lo_live_ff[`FBDC_YA_BK -: 2]};
  assign axes_active.xa = {flt_lo_live_ff[`FBDC_XA_EN], flt_lo_live_ff[`FBDC_XA_BK -: 2]};
  assign axes_active.za = {flt_hi_live_ff[`FBDC_ZA_EN], flt_hi_live_ff[`FBDC_ZA_BK -: 2]};
  assign axes_active.xm = {flt_hi_live_ff[`FBDC_XM_EN], flt_hi_live_ff[`FBDC_XM_BK -: 2]};
  assign axes_active.ym = {flt_hi_live_ff[`FBDC_YM_EN], flt_hi_live_ff[`FBDC_YM_BK -: 2]};
  assign axes_active.zm = {flt_hi_live_ff[`FBDC_ZM_EN], flt_hi_live_ff[`FBDC_ZM_BK -: 2]};

  // delay of bank 0 path in samples; the datapath reads per-bank taps
  assign axis_delay = 8'(TAPS / 2);

  ////////////////////////////////////////////////////////////////////////////
  // coefficient memory
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int b = 0; b < 4; b++) begin
        for (int t = 0; t < TAPS; t++) begin
          coef_mem[b*TAPS+t] <= factory_tap(b, t);
        end
      end
    end else if (req.wr && coef_hit) begin
      coef_mem[coef_idx] <= merge(coef_mem[coef_idx], req.wdata, byte_en);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      coef_ff <= 16'h0000;
    end else begin
      coef_ff <= coef_mem[9'(coef_bank) * 9'(TAPS) + 9'(coef_tap)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data
  always_comb begin
    nxt_rdata = 16'h0000;
    if (req.addr == `FBDC_OFF_PAGE) begin
      nxt_rdata = {8'h00, page_ff};
    end else if (ctrl_page && req.addr == `FBDC_OFF_PINFN) begin
      nxt_rdata = pinfn_ff;
    end else if (ctrl_page && req.addr == `FBDC_OFF_FLT_LO) begin
      nxt_rdata = flt_lo_ff;
    end else if (ctrl_page && req.addr == `FBDC_OFF_FLT_HI) begin
      nxt_rdata = flt_hi_ff;
    end else if (coef_hit) begin
      nxt_rdata = coef_mem[coef_idx];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (req.rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample clock: internal divider or external sync edges
  assign sync_mode = pinfn_ff[`FBDC_SYNC_EN];

  always_ff @(posedge clock) begin
    if (rst || sync_mode) begin
      div_ff <= 32'h0;
    end else if (div_ff == 32'(SAMPLE_DIV - 1)) begin
      div_ff <= 32'h0;
    end else begin
      div_ff <= div_ff + 32'h1;
    end
  end

  assign sample_tick = sync_mode ? sync_edge
                       : (div_ff == 32'(SAMPLE_DIV - 1));

  fbdc_gpio_route u_route (
    .clock(clock),
    .rst(rst),
    .sync_en(pinfn_ff[`FBDC_SYNC_EN]),
    .sync_rise(pinfn_ff[`FBDC_SYNC_EDGE]),
    .sync_pin(pinfn_ff[`FBDC_SYNC_PIN_HI:`FBDC_SYNC_PIN_LO]),
    .dr_en(pinfn_ff[`FBDC_DR_EN]),
    .dr_high(pinfn_ff[`FBDC_DR_POL]),
    .dr_pin(pinfn_ff[`FBDC_DR_PIN_HI:`FBDC_DR_PIN_LO]),
    .data_ready(data_ready),
    .gp_out(gp_out),
    .gp_oe_n(gp_oe_n),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .gp_in(gp_in),
    .sync_edge(sync_edge)
  );

  ////////////////////////////////////////////////////////////////////////////
  property p_pinfn_reset;
    @(posedge clock) $fell(rst) |-> pinfn_ff == 16'h000d;
  endproperty
  a_pinfn_reset: assert property (p_pinfn_reset) else $error("pin function reset wrong");

  property p_no_conflict;
    @(posedge clock) disable iff (rst)
      !(pinfn_ff[7] && pinfn_ff[3] && pinfn_ff[5:4] == pinfn_ff[1:0]);
  endproperty
  a_no_conflict: assert property (p_no_conflict) else $error("two functions on one pin");

  property p_lo_held;
    @(posedge clock) disable iff (rst)
      (req.wr && ctrl_page && req.addr == 7'h16 && !byte_en[1]) |=> $stable(flt_lo_live_ff);
  endproperty
  a_lo_held: assert property (p_lo_held) else $error("lower byte applied early");

  property p_hi_apply;
    @(posedge clock) disable iff (rst)
      (req.wr && ctrl_page && req.addr == 7'h18 && byte_en[1]) |=> flt_hi_live_ff == flt_hi_ff;
  endproperty
  a_hi_apply: assert property (p_hi_apply) else $error("upper write not applied");

  property p_hi_top_zero;
    @(posedge clock) disable iff (rst) flt_hi_live_ff[15:12] == 4'h0;
  endproperty
  a_hi_top_zero: assert property (p_hi_top_zero) else $error("ignored bits stored");

  property p_sync_stops;
    @(posedge clock) disable iff (rst) (sync_mode && !sync_edge) |-> !sample_tick;
  endproperty
  a_sync_stops: assert property (p_sync_stops) else $error("internal tick in sync mode");

  property p_page_write;
    @(posedge clock) disable iff (rst)
      (req.wr && req.addr == 7'h00 && byte_en[0]) |=> page_ff == $past(req.wdata[7:0]);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page not switched");

  property p_dr_drive;
    @(posedge clock) disable iff (rst)
      pinfn_ff[3] |-> !pin_oe_n[pinfn_ff[1:0]]
                      && pin_out[pinfn_ff[1:0]] == (data_ready ~^ pinfn_ff[2]);
  endproperty
  a_dr_drive: assert property (p_dr_drive) else $error("data ready pin wrong");

  property p_flt_reset;
    @(posedge clock) $fell(rst) |-> flt_lo_live_ff == 16'h0000 && flt_hi_live_ff == 16'h0000;
  endproperty
  a_flt_reset: assert property (p_flt_reset) else $error("filter select reset wrong");

  property p_pinfn_top_zero;
    @(posedge clock) disable iff (rst)
      pinfn_ff[15:8] == 8'h00;
  endproperty
  a_pinfn_top_zero: assert property (p_pinfn_top_zero) else $error("unused bits stored");

  property p_lo_apply;
    @(posedge clock) disable iff (rst)
      (req.wr && ctrl_page && req.addr == 7'h16 && byte_en[1]) |=> flt_lo_live_ff == flt_lo_ff;
  endproperty
  a_lo_apply: assert property (p_lo_apply) else $error("lower register not applied");

  property p_hi_held;
    @(posedge clock) disable iff (rst)
      (req.wr && ctrl_page && req.addr == 7'h18 && !byte_en[1]) |=> $stable(flt_hi_live_ff);
  endproperty
  a_hi_held: assert property (p_hi_held) else $error("upper register applied early");

  property p_div_stopped;
    @(posedge clock) disable iff (rst)
      sync_mode |=> div_ff == 32'h0;
  endproperty
  a_div_stopped: assert property (p_div_stopped) else $error("internal divider running");

  property p_sync_released;
    @(posedge clock) disable iff (rst)
      sync_mode |-> pin_oe_n[pinfn_ff[5:4]];
  endproperty
  a_sync_released: assert property (p_sync_released) else $error("sync pin driven");

  property p_sync_cfg_quiet;
    @(posedge clock) disable iff (rst)
      $changed(pinfn_ff[7:4]) |-> !sync_edge;
  endproperty
  a_sync_cfg_quiet: assert property (p_sync_cfg_quiet) else $error("edge on setting change");

  property p_gp_pass;
    @(posedge clock) disable iff (rst)
      (!(pinfn_ff[3] && pinfn_ff[1:0] == 2'h0) && !(pinfn_ff[7] && pinfn_ff[5:4] == 2'h0))
      |-> pin_oe_n[0] == gp_oe_n[0] && pin_out[0] == gp_out[0];
  endproperty
  a_gp_pass: assert property (p_gp_pass) else $error("free pin not general purpose");
endmodule

//--- fbdc_host_model.sv
`timescale 1ns/10ps
module fbdc_host_model (
  // clock
  input wire logic clock,
  // register port
  output fbdc_pkg::fbdc_req_type req,
  output logic [1:0] byte_en,
  input wire logic [15:0] rdata_ff
);
  initial begin
    req = '0;
    byte_en = 2'h0;
  end
  // request held from a falling edge through the taking edge
  task automatic xfer(input logic w, input logic [6:0] a, input logic [15:0] d,
      input logic [1:0] be, output logic [15:0] q);
    @(negedge clock);
    req.wr = w;
    req.rd = ~w;
    req.addr = a;
    req.wdata = d;
    byte_en = be;
    @(negedge clock);
    q = rdata_ff;
    req.wr = 1'b0;
    req.rd = 1'b0;
    // released lanes show the inverse so a stale value cannot pass
    req.addr = ~a;
    req.wdata = ~d;
    byte_en = 2'h0;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic [1:0] be);
    logic [15:0] q;
    xfer(1'b1, a, d, be, q);
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] q);
    xfer(1'b0, a, 16'h0000, 2'h0, q);
  endtask
  task automatic page(input logic [7:0] p);
    wr(7'h00, {8'h00, p}, 2'h3);
  endtask
endmodule

//--- testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clock;
  logic rst;
  logic data_ready;
  logic [1:0] coef_bank;
  logic [6:0] coef_tap;
  logic [3:0] gp_out;
  logic [3:0] gp_oe_n;
  logic [3:0] ext;
  logic [3:0] e4;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [3:0] gp_in;
  logic [15:0] rdata_ff;
  logic [15:0] coef_ff;
  logic [15:0] q;
  logic [7:0] axis_delay;
  logic sample_tick;
  logic sync_mode;
  logic [1:0] byte_en;
  fbdc_pkg::fbdc_req_type req;
  fbdc_pkg::fbdc_axes_type axes_active;
  int err_total;
  int total_checks;
  int lo_v;
  int hi_v;
  int a;
  int b;
  int n;
  int k;
  // pin level: the design where it drives, the outside world elsewhere
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
  fbdc_host_model host (.clock(clock), .req(req), .byte_en(byte_en), .rdata_ff(rdata_ff));
  fbdc_top #(.SAMPLE_DIV(8)) dut (.clock(clock), .rst(rst), .req(req), .byte_en(byte_en),
    .rdata_ff(rdata_ff), .data_ready(data_ready), .axes_active(axes_active),
    .sample_tick(sample_tick), .sync_mode(sync_mode), .axis_delay(axis_delay),
    .coef_bank(coef_bank), .coef_tap(coef_tap), .coef_ff(coef_ff), .gp_out(gp_out),
    .gp_oe_n(gp_oe_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gp_in(gp_in));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  function automatic logic [17:0] axes_of(input int v, input int w);
    return {v[14:9], w[2:0], w[5:3], w[8:6], w[11:9]};
  endfunction
  // counts sample pulses, toggling pin tp every ten cycles when tp < 4
  task automatic ticks(input int cyc, input int tp, output int cnt);
    cnt = 0;
    for (int i = 0; i < cyc; i++) begin
      @(negedge clock);
      if (sample_tick === 1'b1) cnt++;
      if (tp < 4 && i % 10 == 5) ext[tp] = ~ext[tp];
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    summarize();
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    rst = 1'b1;
    data_ready = 1'b0;
    coef_bank = 2'h0;
    coef_tap = 7'h00;
    gp_out = 4'h0;
    gp_oe_n = 4'hf;
    ext = 4'h0;
    void'($urandom(71408));
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    chk("axes_rst", 0, axes_active);
    chk("delay", 60, axis_delay);
    host.page(8'h03);
    host.rd(7'h06, q);
    chk("pinfn_rst", 16'h000d, q);
    host.rd(7'h16, q);
    chk("flt_lo_rst", 0, q);
    host.rd(7'h18, q);
    chk("flt_hi_rst", 0, q);
    host.rd(7'h00, q);
    chk("page", 3, q);
    lo_v = 0;
    hi_v = 0;
    repeat (6) begin
      a = $urandom;
      b = $urandom;
      host.wr(7'h16, a[15:0], 2'h1);
      chk("axes_staged", axes_of(lo_v, hi_v), axes_active);
      host.wr(7'h16, a[15:0], 2'h2);
      host.wr(7'h18, b[15:0], 2'h1);
      chk("axes_half", axes_of(a, hi_v), axes_active);
      host.wr(7'h18, b[15:0], 2'h2);
      lo_v = a;
      hi_v = b;
      chk("axes", axes_of(lo_v, hi_v), axes_active);
      host.rd(7'h18, q);
      chk("flt_hi", hi_v & 32'h0fff, q);
    end
    for (int bk = 0; bk < 4; bk++) begin
      n = $urandom_range(119);
      k = (bk < 2) ? 120 : 32;
      coef_bank = bk[1:0];
      coef_tap = n[6:0];
      @(negedge clock);
      chk("factory", (n < k) ? 32768 / k : 0, coef_ff);
      host.page(8'(5 + 2 * bk + n / 60));
      a = $urandom;
      host.wr(7'(8 + 2 * (n % 60)), a[15:0], 2'h3);
      host.rd(7'(8 + 2 * (n % 60)), q);
      chk("coef_rd", a[15:0], q);
      chk("coef_port", a[15:0], coef_ff);
      host.rd(7'h04, q);
      chk("unused", 0, q);
      host.wr(7'(8 + 2 * (n % 60)), 16'((n < k) ? 32768 / k : 0), 2'h3);
      @(negedge clock);
      chk("coef_restore", (n < k) ? 32768 / k : 0, coef_ff);
    end
    host.page(8'h03);
    for (int p = 0; p < 4; p++) begin
      for (int pol = 0; pol < 2; pol++) begin
        host.wr(7'h06, 16'(8 + pol * 4 + p), 2'h3);
        {data_ready, gp_out, gp_oe_n, ext} = 13'($urandom);
        #1;
        e4 = gp_out;
        e4[p] = pol[0] ? data_ready : ~data_ready;
        chk("pin_out", e4, pin_out);
        e4 = gp_oe_n;
        e4[p] = 1'b0;
        chk("pin_oe_n", e4, pin_oe_n);
        repeat (3) @(negedge clock);
        chk("gp_in", pin_in, gp_in);
      end
      host.wr(7'h06, 16'(8'hcc + p * 17), 2'h3);
      host.rd(7'h06, q);
      chk("conflict", 16'(8'h4c + p * 17), q);
    end
    ext = 4'h0;
    gp_oe_n = 4'hf;
    ticks(80, 4, n);
    chk("int_ticks", 10, n);
    for (int p = 0; p < 4; p++) begin
      host.wr(7'h06, 16'(8'h8c + (p % 2) * 64 + p * 16 + (p + 1) % 4), 2'h3);
      chk("sync_mode", 1, sync_mode);
      ticks(40, 4, n);
      chk("idle", 0, n);
      ticks(40, p, n);
      chk("edges", 2, n);
    end
    summarize();
  end
endmodule
